// File: rtl/tpf_consumer.sv
`default_nettype none
module tpf_consumer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// outer link
	tpf_link_if.rx          link,
	// setup, same as the gateway
	input  wire logic       bonded_channel_count_select,
	input  wire logic [1:0] fec_count,
	// rebuilt inner packets
	output logic            out_valid,
	input  wire logic       out_ready,
	output logic            out_first,
	output logic            out_last,
	output logic [7:0]      out_data,
	output logic            out_rf,
	output logic            out_port_err
);
	typedef enum logic [1:0] {
		R_HDR   = 2'h0,
		R_BODY  = 2'h1,
		R_DRAIN = 2'h2
	} tpf_rstate_t;

	localparam int GM_N = tpf_pkg::NOS * tpf_pkg::NSLOT * tpf_pkg::PAY_BYTES;
	localparam int AC_N = tpf_pkg::NOS * tpf_pkg::PAY_BYTES;
	localparam int SL_N = tpf_pkg::NOS * tpf_pkg::NSLOT;

	tpf_rstate_t          state_reg, state_next;
	logic [7:0]           gmem_reg [GM_N];
	logic [7:0]           gmem_next [GM_N];
	logic [7:0]           acc_e_reg [AC_N];
	logic [7:0]           acc_e_next [AC_N];
	logic [7:0]           acc_o_reg [AC_N];
	logic [7:0]           acc_o_next [AC_N];
	logic [4:0]           gptr_reg [SL_N];
	logic [4:0]           gptr_next [SL_N];
	logic [SL_N-1:0]      pres_reg, pres_next;
	logic [tpf_pkg::NOS-1:0] open_reg, open_next;
	logic [tpf_pkg::NOS-1:0] fga_reg, fga_next;
	logic [tpf_pkg::NOS-1:0] fgb_reg, fgb_next;
	logic [13:0]          grp_reg [tpf_pkg::NOS];
	logic [13:0]          grp_next [tpf_pkg::NOS];
	logic [tpf_pkg::NOS-1:0] sync_reg, sync_next;
	logic [15:0]          cnt_reg [tpf_pkg::NOS];
	logic [15:0]          cnt_next [tpf_pkg::NOS];
	logic [15:0]          len_reg [tpf_pkg::NOS];
	logic [15:0]          len_next [tpf_pkg::NOS];
	logic [15:0]          port_reg [tpf_pkg::NOS];
	logic [15:0]          port_next [tpf_pkg::NOS];
	logic                 cur_os_reg, cur_os_next;
	tpf_pkg::tpf_stream_t cur_st_reg, cur_st_next;
	logic [1:0]           cur_slot_reg, cur_slot_next;
	logic [3:0]           cur_b_reg, cur_b_next;
	logic                 keep_reg, keep_next;
	logic [1:0]           dr_slot_reg, dr_slot_next;
	logic                 ov_reg, ov_next, of_reg, of_next, ol_reg, ol_next;
	logic [7:0]           od_reg, od_next;
	logic                 orf_reg, orf_next, oerr_reg, oerr_next;
	logic [2:0]           hs, ds;
	logic [3:0]           pv;
	logic [1:0]           m_e, m_o;
	logic                 rec_ok, avail, start, last, step, in_g0, in_g1;
	logic [7:0]           rec_val, dbyte;
	logic [4:0]           dptr, ai;
	logic [15:0]          idx, lenv, portv;

	assign out_valid = ov_reg;
	assign out_first = of_reg;
	assign out_last = ol_reg;
	assign out_data = od_reg;
	assign out_rf = orf_reg;
	assign out_port_err = oerr_reg;

	// loss bookkeeping and recovery of the slot being drained
	assign hs = {link.ostream, link.seq[1:0]};
	assign ds = {cur_os_reg, dr_slot_reg};
	assign ai = {cur_os_reg, cur_b_reg};
	assign pv = cur_os_reg ? pres_reg[7:4] : pres_reg[3:0];
	assign m_e = {1'b0, ~pv[0]} + {1'b0, ~pv[2]};
	assign m_o = {1'b0, ~pv[1]} + {1'b0, ~pv[3]};
	always_comb begin
		rec_ok = 1'b0;
		rec_val = acc_e_reg[ai] ^ acc_o_reg[ai];
		if (fga_reg[cur_os_reg] && fgb_reg[cur_os_reg]) begin
			rec_ok = dr_slot_reg[0] ? (m_o == 2'h1) : (m_e == 2'h1);
			rec_val = dr_slot_reg[0] ? acc_o_reg[ai] : acc_e_reg[ai];
		end else if (fga_reg[cur_os_reg]) begin
			rec_ok = (m_e + m_o == 2'h1);
		end else if (fgb_reg[cur_os_reg]) begin
			rec_ok = dr_slot_reg[0] && (m_o == 2'h1) && (m_e == 2'h0);
			rec_val = acc_o_reg[ai];
		end
		rec_ok = rec_ok && !pv[dr_slot_reg];
	end

	// intake, group close, in-order drain and inner reframing
	always_comb begin
		state_next = state_reg;
		gmem_next = gmem_reg;
		acc_e_next = acc_e_reg;
		acc_o_next = acc_o_reg;
		gptr_next = gptr_reg;
		pres_next = pres_reg;
		open_next = open_reg;
		fga_next = fga_reg;
		fgb_next = fgb_reg;
		grp_next = grp_reg;
		sync_next = sync_reg;
		cnt_next = cnt_reg;
		len_next = len_reg;
		port_next = port_reg;
		cur_os_next = cur_os_reg;
		cur_st_next = cur_st_reg;
		cur_slot_next = cur_slot_reg;
		cur_b_next = cur_b_reg;
		keep_next = keep_reg;
		dr_slot_next = dr_slot_reg;
		ov_next = ov_reg && !out_ready;
		of_next = of_reg;
		ol_next = ol_reg;
		od_next = od_reg;
		orf_next = orf_reg;
		oerr_next = oerr_reg;
		link.ready = 1'b0;
		avail = pv[dr_slot_reg] || rec_ok;
		dbyte = pv[dr_slot_reg] ?
			gmem_reg[{ds, cur_b_reg}] : rec_val;
		dptr = pv[dr_slot_reg] ? gptr_reg[ds] : tpf_pkg::PTR_NONE;
		start = ({1'b0, cur_b_reg} == dptr) ||
			(sync_reg[cur_os_reg] && cnt_reg[cur_os_reg] == 16'h0000);
		idx = start ? 16'h0000 : cnt_reg[cur_os_reg];
		lenv = (idx == tpf_pkg::IPLEN_LO) ?
			{len_reg[cur_os_reg][15:8], dbyte} : len_reg[cur_os_reg];
		portv = (idx == tpf_pkg::DPORT_LO) ?
			{port_reg[cur_os_reg][15:8], dbyte} : port_reg[cur_os_reg];
		last = (idx >= tpf_pkg::IPLEN_LO) && (idx + 16'h0001 == lenv);
		in_g0 = portv >= tpf_pkg::G0_PORT_LO && portv <= tpf_pkg::G0_PORT_HI;
		in_g1 = portv >= tpf_pkg::G1_PORT_LO && portv <= tpf_pkg::G1_PORT_HI;
		step = 1'b0;
		case (state_reg)
			R_HDR: begin
				link.ready = 1'b1;
				if (link.valid && link.hdr) begin
					// a newer tunnel group on this outer stream flushes the old first
					if (link.stream == tpf_pkg::ST_TUNNEL &&
						open_reg[link.ostream] &&
						link.seq[15:2] != grp_reg[link.ostream]) begin
						link.ready = 1'b0;
						cur_os_next = link.ostream;
						dr_slot_next = '0;
						cur_b_next = '0;
						state_next = R_DRAIN;
					end else begin
						cur_os_next = link.ostream;
						cur_slot_next = link.seq[1:0];
						cur_st_next = link.stream;
						cur_b_next = '0;
						state_next = R_BODY;
						keep_next = 1'b0;
						if (link.stream == tpf_pkg::ST_TUNNEL) begin
							open_next[link.ostream] = 1'b1;
							grp_next[link.ostream] = link.seq[15:2];
							if (!pres_reg[hs]) begin
								keep_next = 1'b1;
								pres_next[hs] = 1'b1;
								gptr_next[hs] = link.ptr;
							end
						end else begin
							keep_next = open_reg[link.ostream] &&
								link.seq[15:2] == grp_reg[link.ostream] &&
								(link.stream == tpf_pkg::ST_FEC_A ?
								fec_count != tpf_pkg::FEC_NONE :
								fec_count == tpf_pkg::FEC_TWO);
						end
					end
				end
			end
			R_BODY: begin
				link.ready = 1'b1;
				if (link.valid) begin
					if (keep_reg) begin
						case (cur_st_reg)
							tpf_pkg::ST_TUNNEL: begin
								gmem_next[{cur_os_reg, cur_slot_reg, cur_b_reg}] =
									link.data;
								if (cur_slot_reg[0]) begin
									acc_o_next[ai] = acc_o_reg[ai] ^ link.data;
								end else begin
									acc_e_next[ai] = acc_e_reg[ai] ^ link.data;
								end
							end
							tpf_pkg::ST_FEC_A: begin
								acc_e_next[ai] = acc_e_reg[ai] ^ link.data;
							end
							default: begin
								acc_e_next[ai] = acc_e_reg[ai] ^ link.data;
								acc_o_next[ai] = acc_o_reg[ai] ^ link.data;
							end
						endcase
					end
					if (cur_b_reg == tpf_pkg::PAY_LAST) begin
						cur_b_next = '0;
						dr_slot_next = '0;
						state_next = R_HDR;
						if (keep_reg) begin
							if (cur_st_reg == tpf_pkg::ST_FEC_A) begin
								fga_next[cur_os_reg] = 1'b1;
							end
							if (cur_st_reg == tpf_pkg::ST_FEC_B) begin
								fgb_next[cur_os_reg] = 1'b1;
							end
							if ((cur_st_reg == tpf_pkg::ST_TUNNEL &&
								cur_slot_reg == tpf_pkg::SLOT_LAST &&
								fec_count == tpf_pkg::FEC_NONE) ||
								(cur_st_reg == tpf_pkg::ST_FEC_A &&
								fec_count == tpf_pkg::FEC_ONE) ||
								cur_st_reg == tpf_pkg::ST_FEC_B) begin
								state_next = R_DRAIN;
							end
						end
					end else begin
						cur_b_next = cur_b_reg + 1'b1;
					end
				end
			end
			R_DRAIN: begin
				if (!ov_reg || out_ready) begin
					if (!avail) begin
						// unrecoverable: drop the partial, wait for pointer
						sync_next[cur_os_reg] = 1'b0;
						cnt_next[cur_os_reg] = 16'h0000;
						step = 1'b1;
					end else begin
						// bytes ahead of the pointer continue an old packet
						if (start || sync_reg[cur_os_reg]) begin
							ov_next = 1'b1;
							od_next = dbyte;
							of_next = (idx == 16'h0000);
							ol_next = last;
							// outer stream shown on each beat, port group on the last in shared mode: two outer streams
							// may interleave their packets at group edges
							orf_next = cur_os_reg;
							sync_next[cur_os_reg] = 1'b1;
							if (idx == tpf_pkg::IPLEN_HI) begin
								len_next[cur_os_reg] = {dbyte, 8'h00};
							end
							if (idx == tpf_pkg::IPLEN_LO) begin
								len_next[cur_os_reg] = lenv;
							end
							if (idx == tpf_pkg::DPORT_HI) begin
								port_next[cur_os_reg] = {dbyte, 8'h00};
							end
							if (idx == tpf_pkg::DPORT_LO) begin
								port_next[cur_os_reg] = portv;
							end
							cnt_next[cur_os_reg] = last ? 16'h0000 :
								idx + 16'h0001;
							if (last) begin
								orf_next = bonded_channel_count_select ?
									in_g1 : cur_os_reg;
								oerr_next = bonded_channel_count_select &&
									!in_g0 && !in_g1;
							end
						end
						if (cur_b_reg == tpf_pkg::PAY_LAST) begin
							step = 1'b1;
						end else begin
							cur_b_next = cur_b_reg + 1'b1;
						end
					end
					if (step) begin
						cur_b_next = '0;
						if (dr_slot_reg == tpf_pkg::SLOT_LAST) begin
							// group done: free its slots and parity
							for (int i = 0; i < tpf_pkg::NSLOT; i++) begin
								pres_next[{cur_os_reg, i[1:0]}] = 1'b0;
							end
							for (int j = 0; j < tpf_pkg::PAY_BYTES; j++) begin
								acc_e_next[{cur_os_reg, j[3:0]}] = 8'h00;
								acc_o_next[{cur_os_reg, j[3:0]}] = 8'h00;
							end
							fga_next[cur_os_reg] = 1'b0;
							fgb_next[cur_os_reg] = 1'b0;
							open_next[cur_os_reg] = 1'b0;
							state_next = R_HDR;
						end else begin
							dr_slot_next = dr_slot_reg + 1'b1;
						end
					end
				end
			end
			default: begin
				state_next = R_HDR;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= R_HDR;
			gmem_reg <= '{default: 8'h00};
			acc_e_reg <= '{default: 8'h00};
			acc_o_reg <= '{default: 8'h00};
			gptr_reg <= '{default: tpf_pkg::PTR_NONE};
			pres_reg <= '0;
			open_reg <= '0;
			fga_reg <= '0;
			fgb_reg <= '0;
			grp_reg <= '{default: 14'h0000};
			sync_reg <= '0;
			cnt_reg <= '{default: 16'h0000};
			len_reg <= '{default: 16'h0000};
			port_reg <= '{default: 16'h0000};
			cur_os_reg <= 1'b0;
			cur_st_reg <= tpf_pkg::ST_TUNNEL;
			cur_slot_reg <= '0;
			cur_b_reg <= '0;
			keep_reg <= 1'b0;
			dr_slot_reg <= '0;
			ov_reg <= 1'b0;
			of_reg <= 1'b0;
			ol_reg <= 1'b0;
			od_reg <= 8'h00;
			orf_reg <= 1'b0;
			oerr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			gmem_reg <= gmem_next;
			acc_e_reg <= acc_e_next;
			acc_o_reg <= acc_o_next;
			gptr_reg <= gptr_next;
			pres_reg <= pres_next;
			open_reg <= open_next;
			fga_reg <= fga_next;
			fgb_reg <= fgb_next;
			grp_reg <= grp_next;
			sync_reg <= sync_next;
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			port_reg <= port_next;
			cur_os_reg <= cur_os_next;
			cur_st_reg <= cur_st_next;
			cur_slot_reg <= cur_slot_next;
			cur_b_reg <= cur_b_next;
			keep_reg <= keep_next;
			dr_slot_reg <= dr_slot_next;
			ov_reg <= ov_next;
			of_reg <= of_next;
			ol_reg <= ol_next;
			od_reg <= od_next;
			orf_reg <= orf_next;
			oerr_reg <= oerr_next;
		end
	end
endmodule
`default_nettype wire

// File: common/tpf_pkg.sv
`default_nettype none
package tpf_pkg;
	// fixed tunnel payload size and its byte index
	localparam int PAY_BYTES = 16;
	localparam int PAY_W = 4;
	localparam logic [PAY_W-1:0] PAY_LAST = 4'hF;
	// payload pointer, top bit set means no header starts here
	localparam logic [4:0] PTR_NONE = 5'h10;
	// error-correction group of four tunnel packets
	localparam int GRP_W = 2;
	localparam int NSLOT = 4;
	localparam logic [GRP_W-1:0] SLOT_LAST = 2'h3;
	localparam logic [15:0] GRP_LEN = 16'h0004;
	localparam logic [15:0] SEQ_STEP = 16'h0001;
	localparam logic [15:0] SEQ_RST = 16'h0000;
	// outer streams (one per rf channel at most)
	localparam int NOS = 2;
	// inner header byte positions (ipv4, 20-byte header assumed)
	localparam logic [15:0] IPLEN_HI = 16'h0002;
	localparam logic [15:0] IPLEN_LO = 16'h0003;
	localparam logic [15:0] DPORT_HI = 16'h0016;
	localparam logic [15:0] DPORT_LO = 16'h0017;
	// inner port ranges of the two groups in single-stream bonding
	localparam logic [15:0] G0_PORT_LO = 16'h7530;
	localparam logic [15:0] G0_PORT_HI = 16'h7572;
	localparam logic [15:0] G1_PORT_LO = 16'h7594;
	localparam logic [15:0] G1_PORT_HI = 16'h75D6;
	// number of error-correction streams
	localparam logic [1:0] FEC_NONE = 2'h0;
	localparam logic [1:0] FEC_ONE = 2'h1;
	localparam logic [1:0] FEC_TWO = 2'h2;
	typedef enum logic [1:0] {
		ST_TUNNEL = 2'h0,
		ST_FEC_A  = 2'h1,
		ST_FEC_B  = 2'h2
	} tpf_stream_t;
	typedef enum logic [1:0] {
		PIPE_PREAMBLE = 2'h0,
		PIPE_TIMING   = 2'h1,
		PIPE_BASEBAND = 2'h2,
		PIPE_SECURITY = 2'h3
	} tpf_pipe_t;
endpackage
`default_nettype wire

// File: common/tpf_link_if.sv
`default_nettype none
interface tpf_link_if;
	logic                valid;
	logic                ready;
	logic                hdr;
	tpf_pkg::tpf_stream_t stream;
	logic                ostream;
	logic [15:0]         seq;
	logic [4:0]          ptr;
	logic [7:0]          data;
	// gateway end drives packets
	modport gw (
		output valid, hdr, stream, ostream, seq, ptr, data,
		input  ready
	);
	// consumer end takes them
	modport rx (
		input  valid, hdr, stream, ostream, seq, ptr, data,
		output ready
	);
endinterface
`default_nettype wire

// File: rtl/tpf_gateway.sv
`default_nettype none
module tpf_gateway (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// inner packet bytes
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic              in_first,
	input  wire tpf_pkg::tpf_pipe_t in_pipe,
	input  wire logic              in_chan,
	input  wire logic [7:0]        in_data,
	// bonding and correction setup
	input  wire logic              bonded_channel_count_select,
	input  wire logic              bond_en,
	input  wire logic [1:0]        fec_count,
	// outer link
	tpf_link_if.gw                 link
);
	typedef enum logic [1:0] {
		G_FILL = 2'h0,
		G_HDR  = 2'h1,
		G_BODY = 2'h2
	} tpf_gstate_t;

	localparam int MEM_N = tpf_pkg::NOS * tpf_pkg::PAY_BYTES;

	tpf_gstate_t          state_reg, state_next;
	logic [7:0]           mem_reg [MEM_N];
	logic [7:0]           mem_next [MEM_N];
	logic [7:0]           acc_a_reg [MEM_N];
	logic [7:0]           acc_a_next [MEM_N];
	logic [7:0]           acc_b_reg [MEM_N];
	logic [7:0]           acc_b_next [MEM_N];
	logic [tpf_pkg::PAY_W-1:0] fill_reg [tpf_pkg::NOS];
	logic [tpf_pkg::PAY_W-1:0] fill_next [tpf_pkg::NOS];
	logic [4:0]           ptr_reg [tpf_pkg::NOS];
	logic [4:0]           ptr_next [tpf_pkg::NOS];
	logic [15:0]          seq_reg [tpf_pkg::NOS];
	logic [15:0]          seq_next [tpf_pkg::NOS];
	logic                 rf_reg, rf_next;
	logic                 part_reg, part_next;
	logic                 em_os_reg, em_os_next;
	tpf_pkg::tpf_stream_t em_st_reg, em_st_next;
	logic [tpf_pkg::PAY_W-1:0] em_b_reg, em_b_next;
	logic                 split;
	logic                 new_rf;
	logic                 byte_rf;
	logic                 in_os;
	logic [4:0]           wr_idx;
	logic [4:0]           em_idx;
	logic [tpf_pkg::GRP_W-1:0] em_slot;
	logic [7:0]           em_byte;

	// byte being sent and its group position
	assign em_idx = {em_os_reg, em_b_reg};
	assign em_slot = seq_reg[em_os_reg][tpf_pkg::GRP_W-1:0];
	assign em_byte = (em_st_reg == tpf_pkg::ST_TUNNEL) ? mem_reg[em_idx] :
		(em_st_reg == tpf_pkg::ST_FEC_A) ? acc_a_reg[em_idx] :
		acc_b_reg[em_idx];

	// outer packet: one header beat then the fixed payload
	assign link.valid = (state_reg != G_FILL);
	assign link.hdr = (state_reg == G_HDR);
	assign link.stream = em_st_reg;
	assign link.ostream = em_os_reg;
	assign link.seq = (em_st_reg == tpf_pkg::ST_TUNNEL) ?
		seq_reg[em_os_reg] :
		seq_reg[em_os_reg] - tpf_pkg::GRP_LEN;
	assign link.ptr = (em_st_reg == tpf_pkg::ST_TUNNEL) ?
		ptr_reg[em_os_reg] : tpf_pkg::PTR_NONE;
	assign link.data = (state_reg == G_BODY) ? em_byte : 8'h00;

	// packing, partitioning and emission
	always_comb begin
		state_next = state_reg;
		mem_next = mem_reg;
		acc_a_next = acc_a_reg;
		acc_b_next = acc_b_reg;
		fill_next = fill_reg;
		ptr_next = ptr_reg;
		seq_next = seq_reg;
		rf_next = rf_reg;
		part_next = part_reg;
		em_os_next = em_os_reg;
		em_st_next = em_st_reg;
		em_b_next = em_b_reg;
		in_ready = (state_reg == G_FILL);
		// only bonded baseband packets are split over channels
		split = bond_en && (in_pipe == tpf_pkg::PIPE_BASEBAND);
		new_rf = split ? part_reg : in_chan;
		byte_rf = in_first ? new_rf : rf_reg;
		// one outer stream per channel, or one shared stream
		in_os = bonded_channel_count_select ? 1'b0 : byte_rf;
		// shared stream relies on inner ports to tell groups apart
		wr_idx = {in_os, fill_reg[in_os]};
		case (state_reg)
			G_FILL: begin
				if (in_valid) begin
					// inner bytes copied verbatim, headers included
					mem_next[wr_idx] = in_data;
					if (in_first) begin
						rf_next = new_rf;
						if (split) begin
							part_next = ~part_reg;
						end
						if (ptr_reg[in_os] == tpf_pkg::PTR_NONE) begin
							ptr_next[in_os] = {1'b0, fill_reg[in_os]};
						end
					end
					// payload full: send it; rest of the inner packet
					// goes on in the next payload of this stream
					if (fill_reg[in_os] == tpf_pkg::PAY_LAST) begin
						fill_next[in_os] = '0;
						em_os_next = in_os;
						em_st_next = tpf_pkg::ST_TUNNEL;
						em_b_next = '0;
						state_next = G_HDR;
					end else begin
						fill_next[in_os] = fill_reg[in_os] + 1'b1;
					end
				end
			end
			G_HDR: begin
				if (link.ready) begin
					state_next = G_BODY;
				end
			end
			G_BODY: begin
				if (link.ready) begin
					// parity: a over whole group, b over odd slots
					case (em_st_reg)
						tpf_pkg::ST_TUNNEL: begin
							if (em_slot == tpf_pkg::SLOT_LAST &&
								fec_count == tpf_pkg::FEC_NONE) begin
								acc_a_next[em_idx] = 8'h00;
								acc_b_next[em_idx] = 8'h00;
							end else begin
								acc_a_next[em_idx] = acc_a_reg[em_idx] ^
									mem_reg[em_idx];
								if (em_slot[0]) begin
									acc_b_next[em_idx] = acc_b_reg[em_idx] ^
										mem_reg[em_idx];
								end
							end
						end
						tpf_pkg::ST_FEC_A: begin
							acc_a_next[em_idx] = 8'h00;
							if (fec_count != tpf_pkg::FEC_TWO) begin
								acc_b_next[em_idx] = 8'h00;
							end
						end
						default: begin
							acc_b_next[em_idx] = 8'h00;
						end
					endcase
					if (em_b_reg == tpf_pkg::PAY_LAST) begin
						em_b_next = '0;
						state_next = G_FILL;
						if (em_st_reg == tpf_pkg::ST_TUNNEL) begin
							seq_next[em_os_reg] = seq_reg[em_os_reg] +
								tpf_pkg::SEQ_STEP;
							ptr_next[em_os_reg] = tpf_pkg::PTR_NONE;
							// group complete: correction packets follow
							if (em_slot == tpf_pkg::SLOT_LAST &&
								fec_count != tpf_pkg::FEC_NONE) begin
								em_st_next = tpf_pkg::ST_FEC_A;
								state_next = G_HDR;
							end
						end else if (em_st_reg == tpf_pkg::ST_FEC_A &&
							fec_count == tpf_pkg::FEC_TWO) begin
							em_st_next = tpf_pkg::ST_FEC_B;
							state_next = G_HDR;
						end
					end else begin
						em_b_next = em_b_reg + 1'b1;
					end
				end
			end
			default: begin
				state_next = G_FILL;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= G_FILL;
			mem_reg <= '{default: 8'h00};
			acc_a_reg <= '{default: 8'h00};
			acc_b_reg <= '{default: 8'h00};
			fill_reg <= '{default: '0};
			ptr_reg <= '{default: tpf_pkg::PTR_NONE};
			seq_reg <= '{default: tpf_pkg::SEQ_RST};
			rf_reg <= 1'b0;
			part_reg <= 1'b0;
			em_os_reg <= 1'b0;
			em_st_reg <= tpf_pkg::ST_TUNNEL;
			em_b_reg <= '0;
		end else begin
			state_reg <= state_next;
			mem_reg <= mem_next;
			acc_a_reg <= acc_a_next;
			acc_b_reg <= acc_b_next;
			fill_reg <= fill_next;
			ptr_reg <= ptr_next;
			seq_reg <= seq_next;
			rf_reg <= rf_next;
			part_reg <= part_next;
			em_os_reg <= em_os_next;
			em_st_reg <= em_st_next;
			em_b_reg <= em_b_next;
		end
	end
endmodule
`default_nettype wire

// File: tb/tpf_link_props.sv
`default_nettype none
module tpf_link_props (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 srst,
	// link between the two ends
	input wire logic                 valid,
	input wire logic                 ready,
	input wire logic                 hdr,
	input wire tpf_pkg::tpf_stream_t stream,
	input wire logic                 ostream,
	input wire logic [15:0]          seq,
	input wire logic [4:0]           ptr,
	input wire logic [7:0]           data
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic             tk;
	logic [4:0]       cnt_reg, cnt_next;
	logic [1:0]       seen_reg, seen_next;
	logic [1:0][15:0] last_reg, last_next;
	assign tk = valid && ready;
	// data beats since header, last tunnel seq per outer stream
	always_comb begin
		cnt_next = cnt_reg;
		seen_next = seen_reg;
		last_next = last_reg;
		if (tk)
			cnt_next = hdr ? 5'h00 : cnt_reg + 5'h01;
		if (tk && hdr && stream == tpf_pkg::ST_TUNNEL) begin
			seen_next[ostream] = 1'b1;
			last_next[ostream] = seq;
		end
	end
	always_ff @(posedge clk) begin
		cnt_reg <= srst ? 5'h10 : cnt_next;
		seen_reg <= srst ? 2'h0 : seen_next;
		last_reg <= last_next;
	end
	a_valid_hold: assert property (valid && !ready |=> valid)
		else $error("valid dropped before accept");
	a_beat_hold: assert property (
		valid && !ready |=> $stable({hdr, data}))
		else $error("beat changed while stalled");
	a_pkt_len: assert property (tk && hdr |-> cnt_reg == 5'h10)
		else $error("payload not sixteen beats");
	a_no_gap: assert property (tk && !hdr && cnt_reg < 5'h0F |=> valid)
		else $error("gap inside payload");
	a_hdr_stable: assert property (
		valid && !hdr |-> $stable({seq, stream, ostream}))
		else $error("header fields moved in packet");
	a_stream_legal: assert property (valid && hdr |-> stream != 2'h3)
		else $error("fourth stream kind");
	a_fec_hdr: assert property (
		valid && hdr && stream != tpf_pkg::ST_TUNNEL
		|-> ptr == tpf_pkg::PTR_NONE && seq[1:0] == 2'h0)
		else $error("correction header wrong");
	a_seq_step: assert property (
		tk && hdr && stream == tpf_pkg::ST_TUNNEL && seen_reg[ostream]
		|-> seq == last_reg[ostream] + 16'h0001)
		else $error("tunnel sequence skipped");
	c_fec_a: cover property (tk && hdr && stream == tpf_pkg::ST_FEC_A);
	c_fec_b: cover property (tk && hdr && stream == tpf_pkg::ST_FEC_B);
	c_second: cover property (tk && hdr && ostream);
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk, srst, in_valid, in_ready, in_first, in_chan;
	logic               bonded_channel_count_select, bond_en, took, alt;
	logic               out_valid, out_ready, out_first, out_last;
	logic               out_rf, out_port_err;
	logic [1:0]         fec_count;
	logic [7:0]         in_data, out_data;
	tpf_pkg::tpf_pipe_t in_pipe;
	int                 seed = 21, bad_count = 0, checks_done = 0, mr, gk;
	logic [7:0]         got[2][$], exp_b[2][$];
	int                 exp_n[2][$];
	logic               exp_e[2][$];
	tpf_link_if link ();
	tpf_gateway u_tpf_gateway (.clk(clk), .srst(srst), .in_valid(in_valid),
		.in_ready(in_ready), .in_first(in_first), .in_pipe(in_pipe),
		.in_chan(in_chan), .in_data(in_data),
		.bonded_channel_count_select(bonded_channel_count_select),
		.bond_en(bond_en), .fec_count(fec_count), .link(link));
	tpf_consumer u_tpf_consumer (.clk(clk), .srst(srst), .link(link),
		.bonded_channel_count_select(bonded_channel_count_select),
		.fec_count(fec_count), .out_valid(out_valid),
		.out_ready(out_ready), .out_first(out_first),
		.out_last(out_last), .out_data(out_data), .out_rf(out_rf),
		.out_port_err(out_port_err));
	tpf_link_props u_tpf_link_props (.clk(clk), .srst(srst),
		.valid(link.valid), .ready(link.ready), .hdr(link.hdr),
		.stream(link.stream), .ostream(link.ostream), .seq(link.seq),
		.ptr(link.ptr), .data(link.data));
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// byte acceptance seen at the edge, random output stall
	always @(posedge clk) took <= in_valid && in_ready;
	always @(negedge clk) out_ready <= $random(seed) % 4 != 0;
	// offer one byte and hold it until taken
	task automatic put(input logic [7:0] b, input logic f);
		in_valid = 1'b1;
		in_data = b;
		in_first = f;
		@(negedge clk);
		while (!took) @(negedge clk);
	endtask
	// one inner packet with length and port fields, expected rf noted
	task automatic pkt;
		int n, r;
		logic [15:0] dp;
		logic [7:0] b;
		logic g0, g1, bb;
		n = 24 + {$random(seed)} % 32;
		in_pipe = tpf_pkg::tpf_pipe_t'(2'($random(seed)));
		in_chan = 1'($random(seed));
		dp = (in_chan ? tpf_pkg::G1_PORT_LO : tpf_pkg::G0_PORT_LO)
			+ 16'({$random(seed)} % 72);
		g0 = dp >= tpf_pkg::G0_PORT_LO && dp <= tpf_pkg::G0_PORT_HI;
		g1 = dp >= tpf_pkg::G1_PORT_LO && dp <= tpf_pkg::G1_PORT_HI;
		bb = bond_en && in_pipe == tpf_pkg::PIPE_BASEBAND;
		r = bonded_channel_count_select ? g1 : bb ? alt : in_chan;
		alt = alt ^ bb;
		exp_n[r].push_back(n);
		exp_e[r].push_back(bonded_channel_count_select && !g0 && !g1);
		for (int i = 0; i < n; i++) begin
			case (i)
				0: b = 8'h45;
				2: b = 8'(n >> 8);
				3: b = 8'(n);
				22: b = dp[15:8];
				23: b = dp[7:0];
				default: b = 8'($random(seed));
			endcase
			exp_b[r].push_back(b);
			put(b, i == 0);
		end
	endtask
	// compare each delivered packet with the oldest note of its channel
	// bytes gathered per outer stream, since two streams may interleave
	always @(posedge clk) if (!srst && out_valid && out_ready) begin
		gk = bonded_channel_count_select ? 0 : out_rf;
		chk("first", out_first, got[gk].size() == 0);
		got[gk].push_back(out_data);
		if (out_last) begin
			mr = out_rf;
			chk("port_err", out_port_err, exp_e[mr].pop_front());
			chk("length", got[gk].size(), exp_n[mr].pop_front());
			foreach (got[gk][i])
				chk("byte", got[gk][i], exp_b[mr].pop_front());
			got[gk].delete();
		end
	end
	task automatic run(input logic s, bb, input logic [1:0] f, input int np);
		in_valid = 1'b0;
		srst = 1'b1;
		bonded_channel_count_select = s;
		bond_en = bb;
		fec_count = f;
		alt = 1'b0;
		repeat (8) @(negedge clk);
		for (int c = 0; c < 2; c++) begin
			got[c].delete();
			exp_b[c].delete();
			exp_n[c].delete();
			exp_e[c].delete();
		end
		srst = 1'b0;
		repeat (np) pkt();
		in_valid = 1'b0;
		repeat (600) @(negedge clk);
		$display("test select %0d bond %0d fec %0d done", s, bb, f);
	endtask
	initial begin
		{in_first, in_chan, in_data} = 10'h000;
		in_pipe = tpf_pkg::PIPE_PREAMBLE;
		run(1'b0, 1'b0, 2'h0, 12);
		run(1'b0, 1'b1, 2'h1, 16);
		run(1'b1, 1'b1, 2'h2, 16);
		run(1'b1, 1'b0, 2'h1, 12);
		end_sim();
	end
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
